// ### src/nld_cfg.svh
// Opcode patterns, the pair address mask and step, and reset values for the load decoder
`ifndef NLD_CFG_SVH
`define NLD_CFG_SVH
`define NLD_OP_INDIRECT   8'h0C
`define NLD_OP_DIRECT     8'h3C
`define NLD_OP_PAIR       8'h28
`define NLD_IMM_HI        4'h4
`define NLD_NIB_RESET     4'h0
`define NLD_ADDR_RESET    8'h00
`define NLD_PAIR_MASK     8'hFC
`define NLD_PAIR_STEP     8'h01
`endif

// ### src/nld_pkg.sv
// Types shared by the load decoder
`default_nettype none
package nld_pkg;
  typedef logic [3:0] nld_nib_t;
  typedef logic [7:0] nld_byte_t;
  typedef enum logic [2:0]
  {
    NLD_IDLE     = 3'h0,
    NLD_ADDR     = 3'h1,
    NLD_RD_ACC   = 3'h3,
    NLD_RD_LOW   = 3'h2,
    NLD_RD_HIGH  = 3'h6
  } nld_state_t;
endpackage
`default_nettype wire

// ### src/nld_decoder.sv
// Load instruction decoder and executor for a 4-bit core
// Overview of operation
// - Opcode 0C reads memory at the pointer pair into the working nibble.
// - Indirect addresses are the high pointer above the low pointer, eight bits in all.
// - Opcode 3C takes the next byte as an address and loads that word into the working nibble.
// - Opcode 28 is a two-byte pointer-pair load whose second byte is an address.
// - The pair load clears address bits 1:0, loads low from that word and high from the next.
// - Opcode 4k copies k into the working nibble, so k of zero clears it.
`timescale 1ns/1ps
`default_nettype none
`include "nld_cfg.svh"
module nld_decoder
(
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic               clk_en,
  input  wire nld_pkg::nld_byte_t instr_byte,
  input  wire logic               instr_valid,
  output logic                    instr_ready,
  output nld_pkg::nld_byte_t      mem_addr,
  output logic                    mem_rd,
  input  wire nld_pkg::nld_nib_t  mem_rdata,
  output nld_pkg::nld_nib_t       working_nibble_reg,
  output nld_pkg::nld_nib_t       high_pointer_reg,
  output nld_pkg::nld_nib_t       low_pointer_reg
);
  import nld_pkg::*;

  nld_state_t state;
  nld_state_t next_state;
  nld_byte_t  next_mem_addr;
  logic       next_mem_rd;
  logic       next_instr_ready;
  nld_nib_t   next_working_nibble_reg;
  nld_nib_t   next_high_pointer_reg;
  nld_nib_t   next_low_pointer_reg;
  logic       take;

  // A byte is consumed only while ready, so fetch can stall us freely
  assign take = instr_valid && instr_ready;

  // Sequencer: memory data is captured at the end of the mem_rd cycle
  always_comb
  begin
    next_state              = state;
    next_mem_addr           = mem_addr;
    next_mem_rd             = 1'b0;
    next_instr_ready        = instr_ready;
    next_working_nibble_reg = working_nibble_reg;
    next_high_pointer_reg   = high_pointer_reg;
    next_low_pointer_reg    = low_pointer_reg;
    case (state)
      // Opcode decode; immediates finish here, indirect reads stall fetch
      NLD_IDLE:
      begin
        if (take)
        begin
          if (instr_byte == `NLD_OP_INDIRECT)
          begin
            next_mem_addr    = {high_pointer_reg, low_pointer_reg};
            next_mem_rd      = 1'b1;
            next_instr_ready = 1'b0;
            next_state       = NLD_RD_ACC;
          end
          else if (instr_byte == `NLD_OP_DIRECT || instr_byte == `NLD_OP_PAIR)
          begin
            next_mem_addr = instr_byte; // Remember which opcode awaits its address
            next_state    = NLD_ADDR;
          end
          else if (instr_byte[7:4] == `NLD_IMM_HI)
            next_working_nibble_reg = instr_byte[3:0];
        end
      end
      // Address byte; mem_addr still holds the opcode that asked for it
      NLD_ADDR:
      begin
        if (take)
        begin
          next_mem_rd      = 1'b1;
          next_instr_ready = 1'b0;
          if (mem_addr == `NLD_OP_DIRECT)
          begin
            next_mem_addr = instr_byte;
            next_state    = NLD_RD_ACC;
          end
          else
          begin
            next_mem_addr = instr_byte & `NLD_PAIR_MASK;
            next_state    = NLD_RD_LOW;
          end
        end
      end
      // Single read into the working nibble, then reopen fetch
      NLD_RD_ACC:
      begin
        next_working_nibble_reg = mem_rdata;
        next_instr_ready        = 1'b1;
        next_state              = NLD_IDLE;
      end
      // First pair word; fetch stays stalled for the second read
      NLD_RD_LOW:
      begin
        next_low_pointer_reg = mem_rdata;
        next_mem_addr        = mem_addr + `NLD_PAIR_STEP;
        next_mem_rd          = 1'b1;
        next_state           = NLD_RD_HIGH;
      end
      // Second pair word completes the pointer load
      NLD_RD_HIGH:
      begin
        next_high_pointer_reg = mem_rdata;
        next_instr_ready      = 1'b1;
        next_state            = NLD_IDLE;
      end
      // Unused codes recover to idle with fetch open
      default:
      begin
        next_state       = NLD_IDLE;
        next_instr_ready = 1'b1;
      end
    endcase
  end

  // State registers; clk_en low freezes all, and no write port exists
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state              <= NLD_IDLE;
      mem_addr           <= `NLD_ADDR_RESET;
      mem_rd             <= 1'b0;
      instr_ready        <= 1'b1;
      working_nibble_reg <= `NLD_NIB_RESET;
      high_pointer_reg   <= `NLD_NIB_RESET;
      low_pointer_reg    <= `NLD_NIB_RESET;
    end
    else if (clk_en)
    begin
      state              <= next_state;
      mem_addr           <= next_mem_addr;
      mem_rd             <= next_mem_rd;
      instr_ready        <= next_instr_ready;
      working_nibble_reg <= next_working_nibble_reg;
      high_pointer_reg   <= next_high_pointer_reg;
      low_pointer_reg    <= next_low_pointer_reg;
    end
  end

  // Checks

  // Immediate nibble lands one enabled edge after the opcode is taken
  imm_load_a: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && state == NLD_IDLE && take && instr_byte[7:4] == `NLD_IMM_HI)
      |=> working_nibble_reg == $past(instr_byte[3:0]))
    else $error("immediate load wrong");

  // Indirect read goes out on the pointer pair, high part on top
  ind_addr_a: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && state == NLD_IDLE && take && instr_byte == `NLD_OP_INDIRECT)
      |=> mem_rd && mem_addr == {high_pointer_reg, low_pointer_reg})
    else $error("indirect address wrong");

  // Read data reaches the working nibble unchanged
  ind_data_a: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && state == NLD_RD_ACC) |=> working_nibble_reg == $past(mem_rdata))
    else $error("memory load wrong");

  // Loading the working nibble must not disturb the pointer pair
  ind_ptr_a: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && state == NLD_RD_ACC)
      |=> $stable(high_pointer_reg) && $stable(low_pointer_reg))
    else $error("pointer disturbed by load");

  // Direct read uses the second byte as the whole address
  dir_addr_a: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && state == NLD_ADDR && take && mem_addr == `NLD_OP_DIRECT)
      |=> mem_rd && mem_addr == $past(instr_byte) && state == NLD_RD_ACC)
    else $error("direct address wrong");

  // Pair opcode waits for its address byte before any read
  pair_two_a: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && state == NLD_IDLE && take && instr_byte == `NLD_OP_PAIR)
      |=> state == NLD_ADDR)
    else $error("pair not two-byte");

  // First pair word is aligned; a frozen cycle may keep it a while
  pair_align_a: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && state == NLD_ADDR && take && mem_addr == `NLD_OP_PAIR)
      |=> mem_addr[1:0] == 2'h0 ##1 (state == NLD_RD_LOW || mem_addr[1:0] == 2'h1))
    else $error("pair address wrong");

  // Low pointer takes the first word
  pair_low_a: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && state == NLD_RD_LOW) |=> low_pointer_reg == $past(mem_rdata))
    else $error("low pointer load wrong");

  // Second pair read is the very next word
  pair_next_a: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && state == NLD_RD_LOW)
      |=> mem_rd && mem_addr == $past(mem_addr) + `NLD_PAIR_STEP)
    else $error("pair second address wrong");

  // High pointer takes the second word and fetch reopens
  pair_high_a: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && state == NLD_RD_HIGH)
      |=> high_pointer_reg == $past(mem_rdata) && instr_ready)
    else $error("high pointer load wrong");

  // Fetch is stalled for as long as a read is outstanding
  ready_low_a: assert property (@(posedge sys_clk) disable iff (rst)
    (mem_rd |-> !instr_ready))
    else $error("fetch accepted during read");

  // A disabled cycle leaves the state, the working nibble and mem_addr where they were
  hold_freeze_a: assert property (@(posedge sys_clk) disable iff (rst)
    !clk_en |=> $stable(state) && $stable(working_nibble_reg) && $stable(mem_addr))
    else $error("state moved while disabled");

  // Main scenarios
  cov_ind_c: cover property (@(posedge sys_clk) state == NLD_RD_ACC);
  cov_pair_c: cover property (@(posedge sys_clk) state == NLD_RD_HIGH);
  cov_imm_c: cover property (@(posedge sys_clk)
    state == NLD_IDLE && take && instr_byte[7:4] == `NLD_IMM_HI);
  cov_dir_c: cover property (@(posedge sys_clk)
    state == NLD_ADDR && take && mem_addr == `NLD_OP_DIRECT);
  cov_freeze_c: cover property (@(posedge sys_clk) !clk_en && mem_rd);
endmodule
`default_nettype wire

// ### tb/nld_mem_model.sv
// Data memory model for the load decoder
`timescale 1ns/1ps
`default_nettype none
module nld_mem_model
(
  input  wire logic               sys_clk,
  input  wire nld_pkg::nld_byte_t mem_addr,
  input  wire logic               mem_rd,
  output nld_pkg::nld_nib_t       mem_rdata
);
  import nld_pkg::*;
  // Fixed read-only content, four bits a word
  function automatic nld_nib_t word(input nld_byte_t a);
    return a[7:4] ^ a[3:0] ^ 4'h6;
  endfunction
  // Read answers within the strobe cycle, since the decoder captures at its end;
  // outside the strobe the inverse word shows up any sampling at the wrong time
  always_comb
  begin
    if (mem_rd)
      mem_rdata = word(mem_addr);
    else
      mem_rdata = ~word(mem_addr);
  end
endmodule
`default_nettype wire

// ### tb/nld_decoder_tb.sv
// Self-checking bench for the load decoder
`timescale 1ns/1ps
`default_nettype none
module nld_decoder_tb;
  import nld_pkg::*;
  logic      sys_clk = 1'b0;
  logic      rst = 1'b1;
  logic      clk_en = 1'b1;
  logic      instr_valid = 1'b0;
  nld_byte_t instr_byte = 8'h00;
  logic      instr_ready;
  logic      mem_rd;
  nld_byte_t mem_addr;
  nld_nib_t  mem_rdata;
  nld_nib_t  acc;
  nld_nib_t  hi;
  nld_nib_t  lo;
  int        failures = 0;
  int        checks_done = 0;
  // 100 ns clock
  always #50 sys_clk = ~sys_clk;
  nld_decoder uut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .instr_byte(instr_byte),
    .instr_valid(instr_valid), .instr_ready(instr_ready), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_rdata(mem_rdata), .working_nibble_reg(acc), .high_pointer_reg(hi),
    .low_pointer_reg(lo));
  nld_mem_model mem (.sys_clk(sys_clk), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_rdata(mem_rdata));
  // Expected memory word, computed independently
  function automatic nld_nib_t pat(input nld_byte_t a);
    return a[7:4] ^ a[3:0] ^ 4'h6;
  endfunction
  task automatic chk(input string nm, input nld_byte_t exp, input nld_byte_t got);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  // Offer a byte and keep valid up, so back-to-back bytes need no gap
  task automatic send(input nld_byte_t b);
    int n;
    n = 0;
    instr_valid = 1'b1;
    instr_byte = b;
    while (instr_ready !== 1'b1 && n < 20)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n >= 20)
    begin
      failures++;
      $display("unexpected instr_ready before send: expected 1 seen %b", instr_ready);
    end
    @(posedge sys_clk);
    #1;
  endtask
  // Release fetch and wait, bounded, until the decoder accepts again
  task automatic settle();
    int n;
    n = 0;
    instr_valid = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    while (instr_ready !== 1'b1 && n < 20)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n >= 20)
    begin
      failures++;
      $display("unexpected instr_ready after read: expected 1 seen %b", instr_ready);
    end
  endtask
  // Immediates back to back, ending on zero
  task automatic t_imm();
    for (int k = 15; k >= 0; k--)
    begin
      send({4'h4, 4'(k)});
      chk("acc imm", nld_nib_t'(k), acc);
    end
    settle();
    chk("acc clear", 4'h0, acc);
  endtask
  // Pair load from an address whose low bits are set
  task automatic t_pair();
    send(8'h28);
    send(8'hB7);
    chk("pair addr", 8'hB4, mem_addr);
    chk("pair strobe", 8'h01, mem_rd);
    chk("fetch stall", 8'h00, instr_ready);
    settle();
    chk("low ptr", pat(8'hB4), lo);
    chk("high ptr", pat(8'hB5), hi);
  endtask
  task automatic t_ind();
    send(8'h0C);
    chk("ind addr", {pat(8'hB5), pat(8'hB4)}, mem_addr);
    chk("ind strobe", 8'h01, mem_rd);
    settle();
    chk("acc ind", pat({pat(8'hB5), pat(8'hB4)}), acc);
  endtask
  task automatic t_dir();
    send(8'h3C);
    send(8'h5A);
    chk("dir addr", 8'h5A, mem_addr);
    settle();
    chk("acc dir", pat(8'h5A), acc);
  endtask
  // Clock enable, an ignored opcode, a mid-run reset and a frozen pair read
  task automatic t_hold();
    clk_en = 1'b0;
    instr_valid = 1'b1;
    instr_byte = 8'h4A;
    repeat (3) @(posedge sys_clk);
    #1;
    chk("acc frozen", pat(8'h5A), acc);
    clk_en = 1'b1;
    @(posedge sys_clk);
    #1;
    chk("acc enabled", 8'h0A, acc);
    send(8'h3F);
    chk("acc after nop", 8'h0A, acc);
    chk("ptr after nop", {pat(8'hB5), pat(8'hB4)}, {hi, lo});
    rst = 1'b1;
    instr_valid = 1'b0;
    @(posedge sys_clk);
    #1;
    rst = 1'b0;
    chk("acc reset", 8'h00, acc);
    chk("ptr reset", 8'h00, {hi, lo});
    chk("strobe reset", 8'h00, mem_rd);
    chk("ready reset", 8'h01, instr_ready);
    send(8'h28);
    send(8'h13);
    clk_en = 1'b0;
    instr_valid = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    chk("frozen addr", 8'h10, mem_addr);
    chk("frozen low", 8'h00, lo);
    clk_en = 1'b1;
    settle();
    chk("low after freeze", pat(8'h10), lo);
    chk("high after freeze", pat(8'h11), hi);
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence after five reset cycles
  initial
  begin
    repeat (5) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    t_imm();
    t_pair();
    t_ind();
    t_dir();
    t_hold();
    end_of_test();
  end
  // Watchdog well beyond the expected run
  initial
  begin
    #200000;
    failures++;
    end_of_test();
  end
endmodule
`default_nettype wire
